// ### acc_top.sv
// Converter compare/acquire control: comparator, brake, timing, disconnect.
// Assumes an analog core that returns a 12-bit result when its phase ends.
// Assumes one system clock; the converter clock is only an enable.
// Notes on behaviour
// - Brake enabled and compare output 1: assert brake, clear PWM run.
// - After compare brake, PWM stays stopped until software sets run again.
// - Polarity 0: result >= compare; polarity 1: result < compare.
// - Gate enabled: done flag only when compare holds; else every completion.
// - Gate enabled: keep converting, updating result, until done flag sets.
// - Done flag and interrupt enable request the converter interrupt.
// - Compare output is read-only, refreshed after every conversion.
// - Sampling lasts 4 times acquisition field plus 6 converter clocks.
// - Control two bit 0 is the delay count MSB; low byte elsewhere.
// - Disconnect bit 1 forces that channel's digital read to 0.
// - Control two and disconnect registers reset to all zeros.
// - Nine-bit delay: after an external trigger, sampling starts after that many converter clocks; software starts skip it.
// - Done flag set at finish, blocks new starts, cleared by software.
// - Writing start bit begins conversion; reads 1 while busy.
`timescale 1ns/1ps
`include "acc_defs.svh"
module acc_top #(
   parameter int CHANNELS = 8,
   parameter int RES_W = 12
) (
   input wire logic I_SYS_CLK,
   input wire logic I_RESETN,
   input wire logic [7:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output acc_pkg::acc_byte_type O_RDATA,
   input wire logic I_EXT_TRIG,
   input wire logic I_ADC_IE,
   input wire logic I_PWM_RUN_SET,
   input wire logic [RES_W-1:0] I_CORE_RESULT,
   output logic O_CORE_SAMPLE,
   output logic O_CORE_CONVERT,
   input wire logic [CHANNELS-1:0] I_PIN_DIGITAL,
   output logic [CHANNELS-1:0] O_PIN_DIGITAL,
   output logic O_FAULT_BRAKE,
   output logic O_PWM_RUN,
   output logic O_ADC_VECTOR_REQ,
   output logic O_IRQ
);
   import acc_pkg::*;
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   // Sequencer state
   acc_state_type state_ff, nxt_state;
   // Control two fields as separate flops
   logic brake_en_ff, pol_ff, gate_ff, cmpo_ff;
   logic [2:0] aqt_ff;
   logic dly_msb_ff;
   // Delay low byte and disconnect mask
   logic [7:0] dly_lo_ff;
   logic [7:0] disc_ff;
   // Remaining control bytes, compare and result words
   logic [3:0] ctl0_low_ff;
   logic [7:0] ctl1_ff;
   logic [RES_W-1:0] cmp_ff, res_ff;
   // Status flops
   logic done_ff, busy_ff, pwm_run_ff, brake_ff;
   // Interrupt status and mask: bit 0 done, bit 1 brake
   logic [1:0] ist_ff, imsk_ff;
   // One counter shared by delay, sample and convert phases
   logic [8:0] cnt_ff;
   // Converter tick and trigger edge detect
   logic tick, ext_ff, ext_edge;
   // Decoded strobes and compare terms
   logic wr_c0, wr_start, finish, cmp_now, flag_set;
   // Read data before the output register
   acc_byte_type rd_mux;

   // Address match to one offset
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction

   // Divided converter clock as a one-cycle enable, so no second clock domain
   acc_clkdiv u_div (
      .I_SYS_CLK(I_SYS_CLK),
      .I_RESETN(I_RESETN),
      .i_div_sel(ctl1_ff[`ACC_C1_DIV_HI:`ACC_C1_DIV_LO]),
      .o_tick(tick)
   );

   // ----------------------------------------
   // Comparator
   // ----------------------------------------
   // Unsigned compare on fresh core result; polarity picks the sense
   always_comb begin
      if (pol_ff) begin
         cmp_now = (I_CORE_RESULT < cmp_ff);
      end else begin
         cmp_now = (I_CORE_RESULT >= cmp_ff);
      end
   end
   // Finish lasts one cycle; every completion event is judged there
   assign finish = (state_ff == ACC_FINISH);
   assign flag_set = finish && (!gate_ff || cmp_now);
   assign wr_c0 = I_WR && hit(I_ADDR, `ACC_OFS_CTL0);
   // Starts are refused while the done flag stands
   assign wr_start = wr_c0 && I_WDATA[`ACC_C0_START] && !done_ff && !busy_ff;

   // External trigger edge, ignored while busy
   always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         ext_ff <= 1'b0;
      end else begin
         ext_ff <= I_EXT_TRIG;
      end
   end
   // A trigger while busy or done is dropped, not queued
   assign ext_edge = I_EXT_TRIG && !ext_ff && ctl1_ff[`ACC_C1_EXT] && !busy_ff && !done_ff;

   // ----------------------------------------
   // Conversion sequencer
   // ----------------------------------------
   // Counter runs on converter clock ticks only
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ACC_IDLE: begin
            if (ext_edge) begin
               nxt_state = ACC_DELAY;
            end else if (wr_start) begin
               nxt_state = ACC_SAMPLE;
            end
         end
         ACC_DELAY: begin
            // A zero delay passes straight through in one cycle
            if (cnt_ff == 9'h000) begin
               nxt_state = ACC_SAMPLE;
            end
         end
         ACC_SAMPLE: begin
            // Leaves on the tick that would take the count to zero
            if (tick && cnt_ff == 9'h001) begin
               nxt_state = ACC_CONVERT;
            end
         end
         ACC_CONVERT: begin
            // Fixed conversion length in converter ticks
            if (tick && cnt_ff == 9'h001) begin
               nxt_state = ACC_FINISH;
            end
         end
         ACC_FINISH: begin
            // Gated mode loops until a matching result sets the flag
            nxt_state = (gate_ff && !cmp_now) ? ACC_SAMPLE : ACC_IDLE;
         end
         default: begin
            nxt_state = ACC_IDLE;
         end
      endcase
   end
   // State register
   always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         state_ff <= ACC_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end
   // Phase counter loaded on each phase entry
   always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         cnt_ff <= 9'h000;
      end else if (nxt_state != state_ff) begin
         case (nxt_state)
            ACC_DELAY: cnt_ff <= {dly_msb_ff, dly_lo_ff};
            ACC_SAMPLE: cnt_ff <= 9'(`ACC_AQT_STEP * aqt_ff + `ACC_AQT_BASE);
            ACC_CONVERT: cnt_ff <= 9'(`ACC_CONV_CYC);
            default: cnt_ff <= 9'h000;
         endcase
      end else if (state_ff == ACC_FINISH && nxt_state == ACC_SAMPLE) begin
         cnt_ff <= 9'(`ACC_AQT_STEP * aqt_ff + `ACC_AQT_BASE);
      end else if (tick && cnt_ff != 9'h000) begin
         cnt_ff <= cnt_ff - 9'h001;
      end
   end
   // Busy bit reads back as the start bit
   // Stays high across gated retries, so software sees one long conversion
   always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         busy_ff <= 1'b0;
      end else if (wr_start || ext_edge) begin
         busy_ff <= 1'b1;
      end else if (finish && nxt_state == ACC_IDLE) begin
         busy_ff <= 1'b0;
      end
   end
   // Phase levels to the analog core, decoded from the state register
   assign O_CORE_SAMPLE = (state_ff == ACC_SAMPLE);
   assign O_CORE_CONVERT = (state_ff == ACC_CONVERT);

   // ----------------------------------------
   // Result, compare output and done flag
   // ----------------------------------------
   // Result and compare output latch in the finish cycle only
   always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         res_ff <= '0;
         cmpo_ff <= 1'b0;
      end else if (finish) begin
         res_ff <= I_CORE_RESULT;
         cmpo_ff <= cmp_now;
      end
   end
   // Set beats a same-cycle software clear
   always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         done_ff <= 1'b0;
      end else if (flag_set) begin
         done_ff <= 1'b1;
      end else if (wr_c0 && !I_WDATA[`ACC_C0_DONE]) begin
         done_ff <= 1'b0;
      end
   end
   // Vector request is a level; it drops as soon as the enable falls
   assign O_ADC_VECTOR_REQ = done_ff && I_ADC_IE;

   // ----------------------------------------
   // Fault brake and PWM run
   // ----------------------------------------
   // Evaluated with the fresh compare, not the stored bit
   // Brake wins over a same-cycle run set, so a fault is never lost
   always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         brake_ff <= 1'b0;
         pwm_run_ff <= 1'b0;
      end else if (finish && brake_en_ff && cmp_now) begin
         brake_ff <= 1'b1;
         pwm_run_ff <= 1'b0;
      end else if (I_PWM_RUN_SET) begin
         brake_ff <= 1'b0;
         pwm_run_ff <= 1'b1;
      end
   end
   // Outputs straight from flops
   assign O_FAULT_BRAKE = brake_ff;
   assign O_PWM_RUN = pwm_run_ff;

   // ----------------------------------------
   // Interrupt status and mask
   // ----------------------------------------
   // Sticky status; a new event beats a same-cycle write-one clear
   always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         ist_ff <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if ((i == `ACC_IRQ_DONE && flag_set)
                || (i == `ACC_IRQ_BRAKE && finish && brake_en_ff && cmp_now)) begin
               ist_ff[i] <= 1'b1;
            end else if (I_WR && hit(I_ADDR, `ACC_OFS_IST) && I_WDATA[i]) begin
               ist_ff[i] <= 1'b0;
            end
         end
      end
   end
   assign O_IRQ = |(ist_ff & imsk_ff);

   // ----------------------------------------
   // Software registers
   // ----------------------------------------
   // Register writes; read-only bits such as the compare output ignore them
   always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         brake_en_ff <= 1'b0;
         pol_ff <= 1'b0;
         gate_ff <= 1'b0;
         aqt_ff <= 3'h0;
         dly_msb_ff <= 1'b0;
         disc_ff <= `ACC_RST_BYTE;
         ctl0_low_ff <= 4'h0;
         ctl1_ff <= `ACC_RST_BYTE;
         dly_lo_ff <= `ACC_RST_BYTE;
         cmp_ff <= '0;
         imsk_ff <= 2'h0;
      end else if (I_WR) begin
         case (I_ADDR)
            `ACC_OFS_CTL2: begin
               brake_en_ff <= I_WDATA[`ACC_C2_BRAKE];
               pol_ff <= I_WDATA[`ACC_C2_POL];
               gate_ff <= I_WDATA[`ACC_C2_GATE];
               aqt_ff <= I_WDATA[`ACC_C2_AQT_HI:`ACC_C2_AQT_LO];
               dly_msb_ff <= I_WDATA[`ACC_C2_DMSB];
            end
            `ACC_OFS_DISC: disc_ff <= I_WDATA;
            `ACC_OFS_CTL0: ctl0_low_ff <= I_WDATA[3:0];
            `ACC_OFS_CTL1: ctl1_ff <= I_WDATA;
            `ACC_OFS_DLYL: dly_lo_ff <= I_WDATA;
            `ACC_OFS_CMPH: cmp_ff[11:4] <= I_WDATA;
            `ACC_OFS_CMPL: cmp_ff[3:0] <= I_WDATA[3:0];
            `ACC_OFS_IMSK: imsk_ff <= I_WDATA[1:0];
            default: begin
            end
         endcase
      end
   end

   // Digital input path gated per channel
   for (genvar g = 0; g < CHANNELS; g++) begin : g_disc
      assign O_PIN_DIGITAL[g] = I_PIN_DIGITAL[g] & ~disc_ff[g];
   end

   // ----------------------------------------
   // Read port: data the cycle after the strobe
   // ----------------------------------------
   // Unmapped offsets read as zero
   always_comb begin
      case (I_ADDR)
         `ACC_OFS_CTL2: rd_mux = {brake_en_ff, pol_ff, gate_ff, cmpo_ff, aqt_ff, dly_msb_ff};
         `ACC_OFS_DISC: rd_mux = disc_ff;
         `ACC_OFS_CTL0: rd_mux = {done_ff, busy_ff, 2'b00, ctl0_low_ff};
         `ACC_OFS_CTL1: rd_mux = ctl1_ff;
         `ACC_OFS_DLYL: rd_mux = dly_lo_ff;
         `ACC_OFS_RESH: rd_mux = res_ff[11:4];
         `ACC_OFS_RESL: rd_mux = {4'h0, res_ff[3:0]};
         `ACC_OFS_CMPH: rd_mux = cmp_ff[11:4];
         `ACC_OFS_CMPL: rd_mux = {4'h0, cmp_ff[3:0]};
         `ACC_OFS_IST: rd_mux = {6'h00, ist_ff};
         `ACC_OFS_IMSK: rd_mux = {6'h00, imsk_ff};
         default: rd_mux = 8'h00;
      endcase
   end
   // Read data registered and held at zero outside the answer cycle
   always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         O_RDATA <= 8'h00;
      end else if (I_RD) begin
         O_RDATA <= rd_mux;
      end else begin
         O_RDATA <= 8'h00;
      end
   end
endmodule

// ### acc_defs.svh
// Constants for the converter compare/acquire control block.
// Assumes inclusion by bare name from any design or verification file.
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH
// ----------------------------------------
// Register offsets (8-bit address port)
// ----------------------------------------
`define ACC_OFS_CTL2 8'hE2
`define ACC_OFS_DISC 8'hF6
`define ACC_OFS_CTL0 8'hE8
`define ACC_OFS_CTL1 8'hE1
`define ACC_OFS_DLYL 8'hE3
`define ACC_OFS_RESH 8'hC3
`define ACC_OFS_RESL 8'hC2
`define ACC_OFS_CMPH 8'hCF
`define ACC_OFS_CMPL 8'hCE
`define ACC_OFS_IST 8'hF0
`define ACC_OFS_IMSK 8'hF1
// ----------------------------------------
// Field positions
// ----------------------------------------
`define ACC_C2_BRAKE 7
`define ACC_C2_POL 6
`define ACC_C2_GATE 5
`define ACC_C2_CMPO 4
`define ACC_C2_AQT_HI 3
`define ACC_C2_AQT_LO 1
`define ACC_C2_DMSB 0
`define ACC_C0_DONE 7
`define ACC_C0_START 6
`define ACC_C1_EN 0
`define ACC_C1_EXT 1
`define ACC_C1_DIV_HI 5
`define ACC_C1_DIV_LO 4
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define ACC_RST_BYTE 8'h00
`define ACC_AQT_BASE 6
`define ACC_AQT_STEP 4
`define ACC_CONV_CYC 14
`define ACC_IRQ_DONE 0
`define ACC_IRQ_BRAKE 1
`endif

// ### acc_pkg.sv
// Types for the converter compare/acquire control block.
// Assumes acc_defs.svh is compiled alongside.
package acc_pkg;
   typedef enum logic [4:0] {
      ACC_IDLE = 5'b00001,
      ACC_DELAY = 5'b00010,
      ACC_SAMPLE = 5'b00100,
      ACC_CONVERT = 5'b01000,
      ACC_FINISH = 5'b10000
   } acc_state_type;
   typedef logic [7:0] acc_byte_type;
endpackage

// ### acc_clkdiv.sv
// Converter clock enable generator: one-cycle tick at the divided rate.
// Assumes the divide select is stable while converting.
`timescale 1ns/1ps
`include "acc_defs.svh"
module acc_clkdiv (
   input wire logic I_SYS_CLK,
   input wire logic I_RESETN,
   input wire logic [1:0] i_div_sel,
   output logic o_tick
);
   import acc_pkg::*;
   logic [2:0] cnt_ff;
   logic [2:0] lim;
   // ----------------------------------------
   // Divide by 1, 2, 4 or 8
   // ----------------------------------------
   always_comb begin
      lim = 3'((4'h1 << i_div_sel) - 4'h1);
   end
   // Free running counter; restarts at the limit
   always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         cnt_ff <= 3'h0;
      end else if (cnt_ff >= lim) begin
         cnt_ff <= 3'h0;
      end else begin
         cnt_ff <= cnt_ff + 3'h1;
      end
   end
   assign o_tick = (cnt_ff >= lim);
endmodule

// ### acc_core_model.sv
// Behavioural analog core seen from the converter control block.
// Assumes sample and convert phase levels from acc_top, one clock.
`timescale 1ns/1ps
module acc_core_model (
   input wire logic i_clk,
   input wire logic i_sample,
   input wire logic i_convert,
   input wire logic [11:0] i_level,
   output logic [11:0] o_result
);
   // ----------------
   // Result path
   // ----------------
   logic [11:0] held_ff;
   // Level is taken while converting; before that the output is stale
   always_ff @(posedge i_clk) begin
      if (i_convert) held_ff <= i_level;
   end
   // Inverted while sampling, so an early capture cannot match by luck
   assign o_result = i_sample ? ~held_ff : held_ff;
endmodule

// ### acc_props.sv
// Checker for acc_top: read quiet, phase timing, brake, gating.
// Assumes it is bound to acc_top and sees every bus write.
`timescale 1ns/1ps
`include "acc_defs.svh"
module acc_props
   import acc_pkg::*;
#(
   parameter int CHANNELS = 8,
   parameter int RES_W = 12
) (
   input wire logic I_SYS_CLK,
   input wire logic I_RESETN,
   input wire logic [7:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   input acc_byte_type O_RDATA,
   input wire logic I_ADC_IE,
   input wire logic I_PWM_RUN_SET,
   input wire logic O_CORE_SAMPLE,
   input wire logic O_CORE_CONVERT,
   input wire logic [CHANNELS-1:0] I_PIN_DIGITAL,
   input wire logic [CHANNELS-1:0] O_PIN_DIGITAL,
   input wire logic O_FAULT_BRAKE,
   input wire logic O_PWM_RUN,
   input wire logic O_ADC_VECTOR_REQ,
   input wire logic O_IRQ
);
   // ----------------
   // Shadow fields
   // ----------------
   logic [CHANNELS-1:0] disc_ff;
   logic [1:0] mask_ff;
   logic [2:0] aqt_ff;
   logic [1:0] div_ff;
   logic [7:0] samp_ff;
   // Shadows follow bus writes, so no read path is needed here
   always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         disc_ff <= '0;
         mask_ff <= 2'h0;
         aqt_ff <= 3'h0;
         div_ff <= 2'h0;
      end else if (I_WR) begin
         if (I_ADDR == `ACC_OFS_DISC) disc_ff <= I_WDATA[CHANNELS-1:0];
         if (I_ADDR == `ACC_OFS_IMSK) mask_ff <= I_WDATA[1:0];
         if (I_ADDR == `ACC_OFS_CTL2) aqt_ff <= I_WDATA[3:1];
         if (I_ADDR == `ACC_OFS_CTL1) div_ff <= I_WDATA[5:4];
      end
   end
   // Length of the running sample phase in system clocks
   always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
      if (!I_RESETN) samp_ff <= 8'h00;
      else samp_ff <= O_CORE_SAMPLE ? samp_ff + 8'h01 : 8'h00;
   end
   // ----------------
   // Properties
   // ----------------
   default clocking @(posedge I_SYS_CLK); endclocking
   default disable iff (!I_RESETN);
   AST_DISC_GATE: assert property (O_PIN_DIGITAL == (I_PIN_DIGITAL & ~disc_ff))
      else $error("digital input not gated by disconnect bit");
   AST_RD_QUIET: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
      else $error("read data outside the read answer cycle");
   AST_VEC_NEEDS_IE: assert property (O_ADC_VECTOR_REQ |-> I_ADC_IE)
      else $error("vector request without interrupt enable");
   AST_PHASE_EXCL: assert property (!(O_CORE_SAMPLE && O_CORE_CONVERT))
      else $error("sample and convert phases overlap");
   // Only judged at full rate, where one tick is one clock
   AST_SAMPLE_LEN: assert property (($fell(O_CORE_SAMPLE) && div_ff == 2'h0)
      |-> samp_ff == {3'h0, aqt_ff, 2'h0} + 8'h06)
      else $error("sample phase length wrong");
   AST_SAMPLE_TO_CONV: assert property ($fell(O_CORE_SAMPLE) |-> O_CORE_CONVERT)
      else $error("sample phase not followed by conversion");
   AST_BRAKE_STOPS_RUN: assert property ($rose(O_FAULT_BRAKE) |-> ##[0:1] !O_PWM_RUN)
      else $error("brake did not clear pwm run");
   AST_RUN_NEEDS_SET: assert property ($rose(O_PWM_RUN) |-> $past(I_PWM_RUN_SET))
      else $error("pwm run rose without software set");
   AST_IRQ_MASKED: assert property (O_IRQ |-> mask_ff != 2'h0)
      else $error("interrupt raised with all sources masked");
endmodule
bind acc_top acc_props #(
   .CHANNELS(CHANNELS),
   .RES_W(RES_W)
) acc_props_i (
   .I_SYS_CLK, .I_RESETN, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA,
   .I_ADC_IE, .I_PWM_RUN_SET, .O_CORE_SAMPLE, .O_CORE_CONVERT,
   .I_PIN_DIGITAL, .O_PIN_DIGITAL, .O_FAULT_BRAKE, .O_PWM_RUN,
   .O_ADC_VECTOR_REQ, .O_IRQ
);

// ### tb_top.sv
// Self-checking bench for the converter compare/acquire control block.
// Assumes acc_top at default widths and the behavioural core model.
`timescale 1ns/1ps
`include "acc_defs.svh"
module tb_top;
   import acc_pkg::*;
   logic clk, rstn, wr, rd, ext, ie, run_set, samp, conv, brake, run, vec, irq, e;
   logic [7:0] addr, wdata, pins, pins_out, d, ctl;
   logic [11:0] level, core_res, c, v;
   logic [31:0] seed = 32'd34804;
   acc_byte_type rdata;
   int miscompares, total_checks, nsamp;
   acc_top acc_top_i (.I_SYS_CLK(clk), .I_RESETN(rstn), .I_ADDR(addr), .I_WDATA(wdata),
      .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_EXT_TRIG(ext), .I_ADC_IE(ie),
      .I_PWM_RUN_SET(run_set), .I_CORE_RESULT(core_res), .O_CORE_SAMPLE(samp),
      .O_CORE_CONVERT(conv), .I_PIN_DIGITAL(pins), .O_PIN_DIGITAL(pins_out),
      .O_FAULT_BRAKE(brake), .O_PWM_RUN(run), .O_ADC_VECTOR_REQ(vec), .O_IRQ(irq));
   acc_core_model acc_core_model_i (.i_clk(clk), .i_sample(samp), .i_convert(conv),
      .i_level(level), .o_result(core_res));
   // ----------------
   // Helpers
   // ----------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] b);
      @(posedge clk);
      addr <= a;
      wdata <= b;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic chk_reg(input logic [7:0] a, input logic [7:0] b);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk({4'h0, rdata}, {4'h0, b});
   endtask
   // Bounded wait: a hang shows as a missing vector request
   task automatic wait_done();
      for (int n = 0; n < 3000 && vec !== 1'b1; n++) begin
         @(posedge clk);
         #1;
      end
      chk({11'h0, vec}, 12'h001);
   endtask
   // Settings only change while idle, never mid-conversion
   task automatic run_conv(input logic [7:0] c2, input logic [11:0] cv, input logic [11:0] lv);
      level <= lv;
      wr_reg(`ACC_OFS_CMPH, cv[11:4]);
      wr_reg(`ACC_OFS_CMPL, {4'h0, cv[3:0]});
      wr_reg(`ACC_OFS_CTL2, c2);
      wr_reg(`ACC_OFS_CTL0, 8'h40);
      chk_reg(`ACC_OFS_CTL0, 8'h40);
      wait_done();
   endtask
   task automatic pulse_run();
      @(posedge clk);
      run_set <= 1'b1;
      @(posedge clk);
      run_set <= 1'b0;
      @(posedge clk);
      #1 chk({11'h0, run}, 12'h001);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // ----------------
   // Clock, watchdog, tests
   // ----------------
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Whole run needs under two thousand clocks
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      final_report();
   end
   initial begin
      {rstn, wr, rd, ext, run_set} = 5'h00;
      ie = 1'b1;
      {addr, wdata, pins, level} = 36'h0;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      chk_reg(`ACC_OFS_CTL2, 8'h00);
      chk_reg(`ACC_OFS_DISC, 8'h00);
      chk_reg(8'h10, 8'h00);
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         d = 8'(rnd());
         wr_reg(`ACC_OFS_DISC, d);
         pins <= 8'(rnd());
         @(posedge clk);
         #1 chk({4'h0, pins_out}, {4'h0, pins & ~d});
         chk_reg(`ACC_OFS_DISC, d);
      end
      $display("test disconnect done");
      wr_reg(`ACC_OFS_CTL1, 8'h01);
      // Equal values first: the boundary of both polarities
      for (int i = 0; i < 10; i++) begin
         c = 12'(rnd());
         v = (i < 2) ? c : 12'(rnd());
         ctl = {1'b0, i[0], 2'h0, 3'(rnd()), 1'(rnd())};
         run_conv(ctl, c, v);
         e = ctl[6] ? (v < c) : (v >= c);
         chk_reg(`ACC_OFS_CTL2, {ctl[7:5], e, ctl[3:0]});
         chk_reg(`ACC_OFS_RESH, v[11:4]);
         chk_reg(`ACC_OFS_RESL, {4'h0, v[3:0]});
         wr_reg(`ACC_OFS_CTL0, 8'hC0);
         chk_reg(`ACC_OFS_CTL0, 8'h80);
         wr_reg(`ACC_OFS_CTL0, 8'h00);
         chk({11'h0, vec}, 12'h000);
      end
      chk({11'h0, irq}, 12'h000);
      wr_reg(`ACC_OFS_IMSK, 8'h01);
      chk({11'h0, irq}, 12'h001);
      wr_reg(`ACC_OFS_IST, 8'h03);
      chk({11'h0, irq}, 12'h000);
      $display("test compare done");
      level <= 12'h100;
      wr_reg(`ACC_OFS_CMPH, 8'h80);
      wr_reg(`ACC_OFS_CTL2, 8'h20);
      wr_reg(`ACC_OFS_CTL0, 8'h40);
      repeat (200) @(posedge clk);
      #1 chk({11'h0, vec}, 12'h000);
      chk_reg(`ACC_OFS_CTL0, 8'h40);
      level <= 12'h9AB;
      wait_done();
      chk_reg(`ACC_OFS_RESH, 8'h9A);
      wr_reg(`ACC_OFS_CTL0, 8'h00);
      $display("test gated done");
      pulse_run();
      run_conv(8'h80, 12'h000, 12'(rnd()));
      chk({10'h0, brake, run}, 12'h002);
      @(posedge clk);
      ie <= 1'b0;
      @(posedge clk);
      #1 chk({11'h0, vec}, 12'h000);
      ie <= 1'b1;
      wr_reg(`ACC_OFS_CTL0, 8'h00);
      wr_reg(`ACC_OFS_CTL2, 8'h00);
      pulse_run();
      $display("test brake done");
      // Divide by 8 meets the analog minimum; 10 ticks less the entry phase
      wr_reg(`ACC_OFS_CTL1, 8'h31);
      wr_reg(`ACC_OFS_CTL2, 8'h02);
      wr_reg(`ACC_OFS_CTL0, 8'h40);
      nsamp = 0;
      repeat (300) begin
         nsamp += samp;
         @(posedge clk);
         #1;
      end
      chk({11'h0, nsamp > 72 && nsamp <= 80}, 12'h001);
      wait_done();
      wr_reg(`ACC_OFS_CTL0, 8'h00);
      $display("test divider done");
      wr_reg(`ACC_OFS_DLYL, 8'h05);
      wr_reg(`ACC_OFS_CTL2, 8'h01);
      wr_reg(`ACC_OFS_CTL1, 8'h03);
      @(posedge clk);
      ext <= 1'b1;
      repeat (250) @(posedge clk);
      #1 chk({11'h0, samp}, 12'h000);
      e = 1'b0;
      repeat (30) begin
         @(posedge clk);
         #1 e = e | samp;
      end
      chk({11'h0, e}, 12'h001);
      wait_done();
      ext <= 1'b0;
      $display("test trigger delay done");
      final_report();
   end
endmodule
